// ---- verilog/jdb_pkg.sv ----
// Constants, states and carrier types for the jog and DC brake controller.
// Assumes a single 200 MHz clock; frequencies are in 0.01 Hz steps.
`default_nettype none
package jdb_pkg;
    // Clock and time bases
    localparam int CLK_PERIOD_NS = 5;
    localparam int DELAY_UNIT_MS = 100;
    localparam int DELAY_UNIT_CYC = DELAY_UNIT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int RAMP_STEP_US = 100;
    localparam int RAMP_STEP_CYC = RAMP_STEP_US * 1000 / CLK_PERIOD_NS;
    // Frequency scaling and limits
    localparam int FREQ_PER_HZ = 100;
    localparam int JOG_MAX_HZ = 10;
    localparam logic [15:0] JOG_LIMIT = 16'(JOG_MAX_HZ * FREQ_PER_HZ);
    localparam logic [5:0] DELAY_MIN = 6'h01;
    localparam logic [5:0] DELAY_MAX = 6'h32;
    localparam logic [6:0] FORCE_MAX = 7'h64;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_JOGF = 8'h04;
    localparam logic [7:0] ADDR_STARTF = 8'h08;
    localparam logic [7:0] ADDR_RUNF = 8'h0C;
    localparam logic [7:0] ADDR_DELAY = 8'h10;
    localparam logic [7:0] ADDR_FORCE = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    // Field codes
    localparam logic [1:0] SRC_TERMINAL = 2'h1;
    localparam logic [1:0] STOP_COAST = 2'h0;
    localparam logic [1:0] STOP_DECEL = 2'h1;
    localparam logic [1:0] STOP_DCB = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Values after reset
    localparam logic [1:0] RST_RUN_SRC = 2'h1;
    localparam logic [15:0] RST_JOGF = 16'h01F4;
    localparam logic [15:0] RST_STARTF = 16'h0032;
    localparam logic [15:0] RST_RUNF = 16'h1388;
    localparam logic [5:0] RST_DELAY = 6'h05;
    localparam logic [6:0] RST_FORCE = 7'h32;

    typedef struct packed {
        logic [1:0] run_src;
        logic delay_en;
        logic [1:0] jog_stop;
        logic [15:0] jog_freq;
        logic [15:0] start_freq;
        logic [15:0] run_freq;
        logic [5:0] delay;
        logic [6:0] force_pct;
    } jdb_cfg_t;

    typedef struct packed {
        logic jog;
        logic brake;
        logic fwd;
        logic rev;
        logic kp_run;
        logic kp_stop;
    } jdb_pins_t;

    typedef enum logic [6:0] {
        ST_STOP = 7'h01,
        ST_RUN = 7'h02,
        ST_JOG = 7'h04,
        ST_DECEL = 7'h08,
        ST_WAIT = 7'h10,
        ST_BRAKE = 7'h20,
        ST_JBRAKE = 7'h40
    } jdb_state_t;
endpackage
`default_nettype wire

// ---- verilog/jdb_ctrl.sv ----
// Jog and external DC brake control with an AXI4-Lite register slave.
// Assumes terminal and keypad pins are asynchronous and drive a motor stage.
// What this block does
// - Jog output never above 10 Hz
// - Jog takes frequency from jog setting
// - Jog frequency applied as step, no ramp
// - Jog input plus run command starts jogging
// - Jog ends by coast, decel or DC brake
// - Jog input off leaves jog mode
// - No jog at 0 Hz or below start
// - Brake input active enables DC braking
// - Brake delay settable 0.1 to 5.0 s
// - Brake force settable 0 to 100 percent
// - Terminal run: release ramps back to frequency
// - Keypad run: after release output stays off
// - Keypad delayed: coast, then brake, then off
`default_nettype none
module jdb_ctrl
    import jdb_pkg::*;
#(
    parameter int RAMP_CYC = RAMP_STEP_CYC,
    parameter int UNIT_CYC = DELAY_UNIT_CYC
) (
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, low
    input wire logic [7:0] awaddr, // Write address
    input wire logic awvalid, // Write address valid
    output logic awready, // Write address ready
    input wire logic [31:0] wdata, // Write data
    input wire logic [3:0] wstrb, // Write byte strobes
    input wire logic wvalid, // Write data valid
    output logic wready, // Write data ready
    output logic [1:0] bresp, // Write response
    output logic bvalid, // Write response valid
    input wire logic bready, // Write response ready
    input wire logic [7:0] araddr, // Read address
    input wire logic arvalid, // Read address valid
    output logic arready, // Read address ready
    output logic [31:0] rdata, // Read data
    output logic [1:0] rresp, // Read response
    output logic rvalid, // Read data valid
    input wire logic rready, // Read data ready
    input wire logic jog_input, // Jog terminal
    input wire logic ext_dc_brake_input, // External DC brake terminal
    input wire logic forward_run_input, // Forward run terminal
    input wire logic reverse_run_input, // Reverse run terminal
    input wire logic keypad_run_key, // Keypad run key
    input wire logic keypad_stop_key, // Keypad stop key
    output logic [15:0] out_freq, // Output frequency, 0.01 Hz
    output logic out_enable, // Output stage driving
    output logic dc_brake_on, // DC injection active
    output logic [6:0] dc_brake_force, // Injection force, percent
    output logic jog_active // Jogging now
);
    if (RAMP_CYC < 1 || UNIT_CYC < 1) begin : g_chk
        $error("jdb_ctrl: cycle counts must be at least one");
    end

    jdb_pins_t meta_reg, sync_reg, prev_reg;
    jdb_cfg_t cfg_reg, cfg_next;
    jdb_state_t st_reg, st_next;
    logic [15:0] freq_reg, freq_next;
    logic kp_reg, kp_next;
    logic [31:0] ramp_reg, ramp_next, tick_reg, tick_next;
    logic [5:0] dly_reg, dly_next;
    logic en_next, brk_next;
    logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
    logic [7:0] aw_q_reg, aw_q_next;
    logic [31:0] w_q_reg, w_q_next;
    logic [3:0] s_q_reg, s_q_next;
    logic bvalid_next, arready_next, rvalid_next;
    logic [1:0] bresp_next, rresp_next;
    logic [31:0] rdata_next;
    logic terminal, run_cmd, jog_cmd, jog_ok, db, kp_press, stop_press;
    logic ramp_tick, unit_tick, timing, expire, wr_fire;
    logic [15:0] jog_clamp;
    jdb_state_t brake_to;

    // Two-stage synchronisers on all pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end else begin
            meta_reg <= '{jog_input, ext_dc_brake_input, forward_run_input,
                          reverse_run_input, keypad_run_key, keypad_stop_key};
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // Register read value
    function automatic logic [31:0] rd_val(input logic [7:0] a, input jdb_cfg_t c,
                                           input logic [15:0] f, input jdb_state_t s);
        logic [31:0] v;
        v = '0;
        unique case ({a[7:2], 2'b00})
            ADDR_CTRL: v = {26'h0, c.jog_stop, 1'b0, c.delay_en, c.run_src};
            ADDR_JOGF: v = {16'h0, c.jog_freq};
            ADDR_STARTF: v = {16'h0, c.start_freq};
            ADDR_RUNF: v = {16'h0, c.run_freq};
            ADDR_DELAY: v = {26'h0, c.delay};
            ADDR_FORCE: v = {25'h0, c.force_pct};
            ADDR_STATUS: v = {f, 1'b0, s, 8'h0};
            default: v = '0;
        endcase
        return v;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return {a[7:2], 2'b00} <= ADDR_STATUS;
    endfunction

    // AXI4-Lite slave next state
    always_comb begin
        logic [31:0] old, wv;
        logic err;
        old = rd_val(aw_q_reg, cfg_reg, freq_reg, st_reg);
        wv = old;
        err = 1'b0;
        cfg_next = cfg_reg;
        aw_have_next = aw_have_reg;
        w_have_next = w_have_reg;
        aw_q_next = aw_q_reg;
        w_q_next = w_q_reg;
        s_q_next = s_q_reg;
        bvalid_next = bvalid;
        bresp_next = bresp;
        arready_next = arready;
        rvalid_next = rvalid;
        rdata_next = rdata;
        rresp_next = rresp;
        wr_fire = aw_have_reg && w_have_reg && !bvalid;
        for (int i = 0; i < 4; i++) begin
            if (s_q_reg[i]) begin
                wv[i*8 +: 8] = w_q_reg[i*8 +: 8];
            end
        end
        if (awvalid && awready) begin
            aw_have_next = 1'b1;
            aw_q_next = awaddr;
        end
        if (wvalid && wready) begin
            w_have_next = 1'b1;
            w_q_next = wdata;
            s_q_next = wstrb;
        end
        if (bvalid && bready) begin
            bvalid_next = 1'b0;
        end
        if (wr_fire) begin
            aw_have_next = 1'b0;
            w_have_next = 1'b0;
            bvalid_next = 1'b1;
            unique case ({aw_q_reg[7:2], 2'b00})
                ADDR_CTRL: begin
                    err = wv[5:4] == 2'h3;
                    if (!err) begin
                        cfg_next.run_src = wv[1:0];
                        cfg_next.delay_en = wv[2];
                        cfg_next.jog_stop = wv[5:4];
                    end
                end
                ADDR_JOGF: cfg_next.jog_freq = wv[15:0];
                ADDR_STARTF: cfg_next.start_freq = wv[15:0];
                ADDR_RUNF: cfg_next.run_freq = wv[15:0];
                ADDR_DELAY: begin
                    err = wv[31:6] != '0 || wv[5:0] < DELAY_MIN || wv[5:0] > DELAY_MAX;
                    if (!err) cfg_next.delay = wv[5:0];
                end
                ADDR_FORCE: begin
                    err = wv[31:7] != '0 || wv[6:0] > FORCE_MAX;
                    if (!err) cfg_next.force_pct = wv[6:0];
                end
                ADDR_STATUS: err = 1'b0;
                default: err = 1'b1;
            endcase
            bresp_next = err ? RESP_SLVERR : RESP_OKAY;
        end
        if (arvalid && arready) begin
            arready_next = 1'b0;
            rvalid_next = 1'b1;
            rdata_next = rd_val(araddr, cfg_reg, freq_reg, st_reg);
            rresp_next = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid_next = 1'b0;
            arready_next = 1'b1;
        end
    end

    // AXI4-Lite slave registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_reg <= '{RST_RUN_SRC, 1'b0, STOP_COAST, RST_JOGF, RST_STARTF,
                         RST_RUNF, RST_DELAY, RST_FORCE};
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_q_reg <= '0;
            w_q_reg <= '0;
            s_q_reg <= '0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else begin
            cfg_reg <= cfg_next;
            aw_have_reg <= aw_have_next;
            w_have_reg <= w_have_next;
            aw_q_reg <= aw_q_next;
            w_q_reg <= w_q_next;
            s_q_reg <= s_q_next;
            awready <= !aw_have_next && !bvalid_next;
            wready <= !w_have_next && !bvalid_next;
            bvalid <= bvalid_next;
            bresp <= bresp_next;
            arready <= arready_next || (!rvalid_next && !arready);
            rvalid <= rvalid_next;
            rdata <= rdata_next;
            rresp <= rresp_next;
        end
    end

    // Motor sequence next state
    always_comb begin
        terminal = cfg_reg.run_src == SRC_TERMINAL;
        db = sync_reg.brake;
        kp_press = sync_reg.kp_run && !prev_reg.kp_run;
        stop_press = sync_reg.kp_stop && !prev_reg.kp_stop;
        run_cmd = terminal ? (sync_reg.fwd || sync_reg.rev) : kp_reg;
        jog_cmd = sync_reg.jog && (run_cmd || (terminal && sync_reg.kp_run));
        jog_ok = cfg_reg.jog_freq != '0 && cfg_reg.jog_freq >= cfg_reg.start_freq;
        jog_clamp = cfg_reg.jog_freq > JOG_LIMIT ? JOG_LIMIT : cfg_reg.jog_freq;
        brake_to = (terminal || !cfg_reg.delay_en) ? ST_BRAKE : ST_WAIT;
        ramp_tick = ramp_reg == 32'(RAMP_CYC - 1);
        ramp_next = ramp_tick ? '0 : ramp_reg + 32'h1;
        timing = st_reg == ST_WAIT || st_reg == ST_JBRAKE;
        unit_tick = tick_reg == 32'(UNIT_CYC - 1);
        tick_next = (unit_tick || !timing) ? '0 : tick_reg + 32'h1;
        dly_next = !timing ? '0 : dly_reg + {5'h0, unit_tick};
        expire = dly_reg >= cfg_reg.delay;
        st_next = st_reg;
        freq_next = freq_reg;
        kp_next = kp_reg;
        unique case (st_reg)
            ST_STOP: begin
                freq_next = '0;
                if (db) st_next = brake_to;
                else if (jog_cmd && jog_ok) begin
                    st_next = ST_JOG;
                    freq_next = jog_clamp;
                end else if (run_cmd) st_next = ST_RUN;
            end
            ST_RUN, ST_DECEL: begin
                if (db) begin
                    st_next = brake_to;
                    freq_next = '0;
                end else if (run_cmd) begin
                    st_next = ST_RUN;
                    if (ramp_tick && freq_reg < cfg_reg.run_freq) freq_next = freq_reg + 16'h1;
                    if (ramp_tick && freq_reg > cfg_reg.run_freq) freq_next = freq_reg - 16'h1;
                end else begin
                    st_next = ST_DECEL;
                    if (freq_reg == '0) st_next = ST_STOP;
                    else if (ramp_tick) freq_next = freq_reg - 16'h1;
                end
            end
            ST_JOG: begin
                freq_next = jog_clamp;
                if (db) begin
                    st_next = brake_to;
                    freq_next = '0;
                end else if (!jog_cmd) begin
                    unique case (cfg_reg.jog_stop)
                        STOP_DECEL: st_next = ST_DECEL;
                        STOP_DCB: st_next = ST_JBRAKE;
                        default: st_next = ST_STOP;
                    endcase
                    if (cfg_reg.jog_stop != STOP_DECEL) freq_next = '0;
                end
            end
            ST_WAIT: begin
                if (!db) st_next = ST_STOP;
                else if (expire) st_next = ST_BRAKE;
            end
            ST_BRAKE: begin
                if (!db) st_next = (terminal && run_cmd) ? ST_RUN : ST_STOP;
            end
            ST_JBRAKE: begin
                if (db) st_next = brake_to;
                else if (expire) st_next = ST_STOP;
            end
            default: st_next = ST_STOP;
        endcase
        if (stop_press || (!terminal && (st_next == ST_BRAKE || st_next == ST_WAIT))) begin
            kp_next = 1'b0;
        end else if (kp_press && !terminal) begin
            kp_next = 1'b1;
        end
        en_next = st_next == ST_RUN || st_next == ST_JOG || st_next == ST_DECEL;
        brk_next = st_next == ST_BRAKE || st_next == ST_JBRAKE;
    end

    // Motor sequence registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= ST_STOP;
            freq_reg <= '0;
            kp_reg <= 1'b0;
            ramp_reg <= '0;
            tick_reg <= '0;
            dly_reg <= '0;
            out_freq <= '0;
            out_enable <= 1'b0;
            dc_brake_on <= 1'b0;
            dc_brake_force <= '0;
            jog_active <= 1'b0;
        end else begin
            st_reg <= st_next;
            freq_reg <= freq_next;
            kp_reg <= kp_next;
            ramp_reg <= ramp_next;
            tick_reg <= tick_next;
            dly_reg <= dly_next;
            out_freq <= freq_next;
            out_enable <= en_next;
            dc_brake_on <= brk_next;
            dc_brake_force <= brk_next ? cfg_reg.force_pct : '0;
            jog_active <= st_next == ST_JOG;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_jog_limit;
        jog_active |-> out_freq <= JOG_LIMIT;
    endproperty
    a_jog_limit: assert property (p_jog_limit) else $error("jog above limit");
    property p_jog_step;
        $rose(jog_active) |-> out_freq == jog_clamp || $changed(cfg_reg);
    endproperty
    a_jog_step: assert property (p_jog_step) else $error("jog not stepped");
    property p_jog_refuse;
        st_reg == ST_STOP && !jog_ok && !db |=> st_reg != ST_JOG;
    endproperty
    a_jog_refuse: assert property (p_jog_refuse) else $error("jog not refused");
    property p_jog_off;
        st_reg == ST_JOG && !sync_reg.jog && !db |=> !jog_active;
    endproperty
    a_jog_off: assert property (p_jog_off) else $error("jog kept running");
    property p_jog_coast;
        st_reg == ST_JOG && !jog_cmd && !db && cfg_reg.jog_stop == STOP_COAST
            |=> !out_enable && !dc_brake_on;
    endproperty
    a_jog_coast: assert property (p_jog_coast) else $error("coast stop wrong");
    property p_brake_on;
        db && terminal && st_reg == ST_RUN |=> dc_brake_on ##0 dc_brake_force == cfg_reg.force_pct;
    endproperty
    a_brake_on: assert property (p_brake_on) else $error("brake not applied");
    property p_term_resume;
        st_reg == ST_BRAKE && !db && terminal && run_cmd |=> out_enable && st_reg == ST_RUN;
    endproperty
    a_term_resume: assert property (p_term_resume) else $error("no resume");
    property p_kp_off;
        st_reg == ST_BRAKE && !db && !terminal |=> !out_enable [*2];
    endproperty
    a_kp_off: assert property (p_kp_off) else $error("keypad output not off");
    property p_wait_coast;
        st_reg == ST_WAIT |-> !out_enable && !dc_brake_on;
    endproperty
    a_wait_coast: assert property (p_wait_coast) else $error("wait not coasting");
    property p_bad_delay;
        wr_fire && {aw_q_reg[7:2], 2'b00} == ADDR_DELAY && w_q_reg[5:0] > DELAY_MAX
            && s_q_reg[0] |=> $stable(cfg_reg.delay) && bresp == RESP_SLVERR;
    endproperty
    a_bad_delay: assert property (p_bad_delay) else $error("bad delay stored");
endmodule
`default_nettype wire

// ---- test/jdb_operator.sv ----
// Operator side model: terminal switches and keypad keys of the drive.
// Assumes the bench calls its tasks and a 200 MHz aclk runs.
`default_nettype none
module jdb_operator
    import jdb_pkg::*;
(
    input wire logic aclk, // System clock
    output var jdb_pins_t pins // Terminal and key levels
);
    timeunit 1ns;
    timeprecision 100ps;

    // All switches open at power up
    initial pins = '0;

    // Set terminal switch levels after a clock edge
    task automatic hold(input logic jog, input logic brk, input logic fwd, input logic rev);
        @(posedge aclk);
        pins.jog <= jog;
        pins.brake <= brk;
        pins.fwd <= fwd;
        pins.rev <= rev;
    endtask

    // Press one keypad key long enough to pass the synchroniser
    task automatic key(input logic run);
        @(posedge aclk);
        if (run) begin
            pins.kp_run <= 1'b1;
        end else begin
            pins.kp_stop <= 1'b1;
        end
        repeat (4) @(posedge aclk);
        pins.kp_run <= 1'b0;
        pins.kp_stop <= 1'b0;
    endtask

    task automatic run_level(input logic v);
        @(posedge aclk);
        pins.kp_run <= v;
    endtask
endmodule
`default_nettype wire

// ---- test/test_jdb_ctrl.sv ----
// Bench for the jog and DC brake controller: AXI4-Lite tasks and pin scenarios.
// Assumes short ramp and delay counts given through the design's parameters.
`default_nettype none
`define CHECK(nm, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module test_jdb_ctrl
    import jdb_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic out_enable, dc_brake_on, jog_active;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [15:0] out_freq;
    logic [6:0] dc_brake_force;
    logic [3:0] ws;
    jdb_pins_t pins;
    int fail_count, compares;
    logic [7:0] ta [6] = '{ADDR_DELAY, ADDR_DELAY, ADDR_DELAY, ADDR_DELAY, ADDR_FORCE, ADDR_FORCE};
    logic [31:0] td [6] = '{32'h0, 32'h33, 32'h32, 32'h1, 32'h65, 32'h64};
    logic [1:0] tr [6] = '{RESP_SLVERR, RESP_SLVERR, RESP_OKAY, RESP_OKAY, RESP_SLVERR, RESP_OKAY};
    logic [7:0] ra [6] = '{ADDR_CTRL, ADDR_JOGF, ADDR_STARTF, ADDR_RUNF, ADDR_DELAY, ADDR_FORCE};
    logic [31:0] rx [6] = '{32'h1, 32'h1F4, 32'h32, 32'h1388, 32'h5, 32'h32};
    logic [15:0] jf [3] = '{16'h0BB8, 16'h03E8, 16'h0032};
    logic [15:0] jx [3] = '{16'h03E8, 16'h03E8, 16'h0032};
    logic [15:0] bad [2] = '{16'h0000, 16'h0031};
    logic ex_en [3] = '{1'b0, 1'b1, 1'b0};
    logic ex_db [3] = '{1'b0, 1'b0, 1'b1};

    jdb_ctrl #(.RAMP_CYC(4), .UNIT_CYC(10)) i_dut (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(ws),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .jog_input(pins.jog),
        .ext_dc_brake_input(pins.brake), .forward_run_input(pins.fwd),
        .reverse_run_input(pins.rev), .keypad_run_key(pins.kp_run),
        .keypad_stop_key(pins.kp_stop), .out_freq(out_freq), .out_enable(out_enable),
        .dc_brake_on(dc_brake_on), .dc_brake_force(dc_brake_force), .jog_active(jog_active));
    jdb_operator i_op (.aclk(aclk), .pins(pins));

    // Free running clock, 5 ns period
    always #2.5 aclk = ~aclk;

    // Write one word and check the response code
    task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        `CHECK("bresp", er, bresp)
        bready <= 1'b0;
    endtask

    // Read one word and check data and response code
    task automatic r(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        `CHECK("rdata", ed, rdata)
        `CHECK("rresp", er, rresp)
        rready <= 1'b0;
    endtask

    // Let edges pass, then sample settled outputs
    task automatic t(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask

    task automatic summarize();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Hang guard well beyond the scenario length
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        summarize();
    end

    // Main sequence
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        ws = 4'hF;
        fail_count = 0;
        compares = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 6; i++) r(ra[i], rx[i], RESP_OKAY);
        r(8'h1C, 32'h0, RESP_SLVERR);
        w(ADDR_STATUS, 32'hFFFF_FFFF, RESP_OKAY);
        r(ADDR_STATUS, 32'h0000_0100, RESP_OKAY);
        // Low byte strobe only: upper bytes keep the stored value
        ws <= 4'h1;
        w(ADDR_DELAY, 32'hFFFF_FF07, RESP_OKAY);
        w(ADDR_DELAY, 32'hFFFF_FF33, RESP_SLVERR);
        ws <= 4'hF;
        r(ADDR_DELAY, 32'h7, RESP_OKAY);
        for (int i = 0; i < 6; i++) w(ta[i], td[i], tr[i]);
        r(ADDR_DELAY, 32'h1, RESP_OKAY);
        r(ADDR_FORCE, 32'h64, RESP_OKAY);
        w(ADDR_RUNF, 32'h20, RESP_OKAY);
        foreach (bad[i]) begin
            w(ADDR_JOGF, {16'h0, bad[i]}, RESP_OKAY);
            i_op.hold(1'b1, 1'b0, 1'b1, 1'b0);
            t(6);
            `CHECK("jog_active", 1'b0, jog_active)
            i_op.hold(1'b0, 1'b0, 1'b0, 1'b0);
            t(200);
        end
        foreach (jf[i]) begin
            w(ADDR_JOGF, {16'h0, jf[i]}, RESP_OKAY);
            i_op.hold(1'b1, 1'b0, 1'b1, 1'b0);
            t(4);
            `CHECK("jog_active", 1'b1, jog_active)
            `CHECK("out_freq", jx[i], out_freq)
            i_op.hold(1'b0, 1'b0, 1'b0, 1'b0);
            t(5);
            `CHECK("jog_active", 1'b0, jog_active)
        end
        // every stop code, and the illegal one
        w(ADDR_CTRL, 32'h31, RESP_SLVERR);
        w(ADDR_JOGF, 32'h40, RESP_OKAY);
        for (int c = 0; c < 3; c++) begin
            w(ADDR_CTRL, 32'h1 | (c << 4), RESP_OKAY);
            i_op.hold(1'b1, 1'b0, 1'b1, 1'b0);
            t(8);
            i_op.hold(1'b0, 1'b0, 1'b0, 1'b0);
            t(5);
            `CHECK("out_enable", ex_en[c], out_enable)
            `CHECK("dc_brake_on", ex_db[c], dc_brake_on)
            t(400);
            `CHECK("out_enable", 1'b0, out_enable)
        end
        // keypad run key jogs in terminal mode
        w(ADDR_CTRL, 32'h1, RESP_OKAY);
        i_op.run_level(1'b1);
        i_op.hold(1'b1, 1'b0, 1'b0, 1'b0);
        t(6);
        `CHECK("jog_active", 1'b1, jog_active)
        i_op.run_level(1'b0);
        i_op.hold(1'b0, 1'b0, 1'b0, 1'b0);
        t(20);
        i_op.hold(1'b0, 1'b0, 1'b0, 1'b1);
        t(200);
        `CHECK("out_freq", 16'h0020, out_freq)
        i_op.hold(1'b0, 1'b1, 1'b0, 1'b1);
        t(5);
        `CHECK("dc_brake_on", 1'b1, dc_brake_on)
        `CHECK("dc_brake_force", 7'h64, dc_brake_force)
        i_op.hold(1'b0, 1'b0, 1'b0, 1'b1);
        t(5);
        `CHECK("ramping", 1'b1, out_enable && out_freq < 16'h0020)
        `CHECK("dc_brake_force", 7'h00, dc_brake_force)
        t(200);
        `CHECK("out_freq", 16'h0020, out_freq)
        i_op.hold(1'b0, 1'b0, 1'b0, 1'b0);
        t(200);
        w(ADDR_CTRL, 32'h0, RESP_OKAY);
        i_op.key(1'b1);
        t(10);
        `CHECK("out_enable", 1'b1, out_enable)
        i_op.hold(1'b0, 1'b1, 1'b0, 1'b0);
        t(5);
        `CHECK("dc_brake_on", 1'b1, dc_brake_on)
        i_op.hold(1'b0, 1'b0, 1'b0, 1'b0);
        t(50);
        `CHECK("off", 1'b0, out_enable || dc_brake_on)
        // keypad run, coast for delay, brake, off
        w(ADDR_CTRL, 32'h4, RESP_OKAY);
        i_op.key(1'b1);
        t(10);
        i_op.hold(1'b0, 1'b1, 1'b0, 1'b0);
        t(5);
        `CHECK("coast", 1'b0, out_enable || dc_brake_on)
        t(15);
        `CHECK("dc_brake_on", 1'b1, dc_brake_on)
        i_op.hold(1'b0, 1'b0, 1'b0, 1'b0);
        t(50);
        `CHECK("off", 1'b0, out_enable || dc_brake_on)
        // Keypad stop key ends a keypad run
        i_op.key(1'b1);
        t(10);
        `CHECK("out_enable", 1'b1, out_enable)
        i_op.key(1'b0);
        t(50);
        `CHECK("out_enable", 1'b0, out_enable)
        summarize();
    end
endmodule
`default_nettype wire
